// ### hw/drc_defines.svh
`ifndef DRC_DEFINES_SVH
`define DRC_DEFINES_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define DRC_ADDR_W 5
`define DRC_WORD_BYTES 5'h04
`define DRC_OFF_CONFIG 5'h00
`define DRC_OFF_WAVE0 5'h04
`define DRC_OFF_STATUS 5'h10
`define DRC_CONFIG_RESET 32'h0000_0000
`define DRC_WAVE_RESET 32'hffff_ffff

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define DRC_F_BANK_EN 3:0
`define DRC_F_ROW_BITS 5:4
`define DRC_F_HALF_RATE 6
`define DRC_F_PRECHARGE 10:7
`define DRC_F_CBR_WIDTH 14:11
`define DRC_F_LATCH_DLY 16:15
`define DRC_F_INTERVAL 31:17
`define DRC_F_ST_STATE 2:0
`define DRC_F_ST_SUSPEND 3
`define DRC_F_ST_PENDING 4

// ----------------------------------------
// Timing constants
// ----------------------------------------
`define DRC_MIN_PRECHARGE 5'h02
`define DRC_CBR_CAS_LEAD 5'h01
`define DRC_WAIT_LAST 5'h01
`define DRC_INTERVAL_PAD 2'h0
`define DRC_ROW_MASK_FULL 12'hfff
`define DRC_ROW_SEL_MAX 2'h3
`endif

// ### hw/drc_pkg.sv
package drc_pkg;
  // Sequencer states of the memory controller
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACCESS = 3'h1,
    ST_PRECHARGE = 3'h2,
    ST_CBR_CAS = 3'h3,
    ST_CBR_RAS = 3'h4
  } drc_state_type;
endpackage : drc_pkg

// ### hw/drc_refresh_timer.sv
`include "drc_defines.svh"
module drc_refresh_timer
  import drc_pkg::*;
#(
  parameter int IntervalW = 15
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic memTick, // One pulse per memory clock
  input wire logic timerEnable, // Any bank enabled
  input wire logic [IntervalW-1:0] interval,
  input wire logic refreshAck, // Refresh started
  output logic refreshPending
);
  logic [IntervalW+1:0] count_q; // Memory clocks left
  logic pending_q; // Refresh owed
  logic expire;

  assign expire = timerEnable && memTick && (count_q == '0);
  assign refreshPending = pending_q;

  // ----------------------------------------
  // Interval counter
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
    end else if (!timerEnable) begin
      count_q <= count_q;
    end else if (expire) begin
      count_q <= {interval, `DRC_INTERVAL_PAD} - 1'b1;
    end else if (memTick) begin
      count_q <= count_q - 1'b1;
    end
  end

  // Request flag; a new expiry wins over the acknowledge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_q <= 1'b0;
    end else if (expire) begin
      pending_q <= 1'b1;
    end else if (refreshAck) begin
      pending_q <= 1'b0;
    end
  end

  property p_frozen;
    @(posedge core_clk) disable iff (!rst_b)
    !timerEnable |=> $stable(count_q);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("refresh timer ran with no bank enabled");

  property p_reload;
    @(posedge core_clk) disable iff (!rst_b)
    expire |=> count_q == $past({interval, `DRC_INTERVAL_PAD}) - 1'b1;
  endproperty
  a_reload: assert property (p_reload)
    else $error("refresh timer reload wrong");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_b)
    (pending_q && !refreshAck) |=> pending_q;
  endproperty
  a_hold: assert property (p_hold)
    else $error("pending refresh lost");
endmodule : drc_refresh_timer

// ### hw/drc_read_latch.sv
`include "drc_defines.svh"
module drc_read_latch
  import drc_pkg::*;
#(
  parameter int DataW = 32,
  parameter int DelayMax = 3
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic casRelease, // Column strobe deasserts at this edge
  input wire logic zeroFill, // Return zeros for a dead access
  input wire logic [1:0] latchDelay,
  input wire logic [DataW-1:0] memData,
  output logic [DataW-1:0] readData,
  output logic readValid
);
  logic [DelayMax:1] pipe_q; // Delayed release pulses
  logic [DelayMax:0] taps;
  logic take;

  assign taps = {pipe_q, casRelease};
  assign take = taps[latchDelay];

  // Delay line in CPU clocks
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= taps[DelayMax-1:0];
    end
  end

  // Capture register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      readData <= '0;
      readValid <= 1'b0;
    end else begin
      readValid <= take || zeroFill;
      if (zeroFill) begin
        readData <= '0;
      end else if (take) begin
        readData <= memData;
      end
    end
  end

  property p_lat0;
    @(posedge core_clk) disable iff (!rst_b)
    (casRelease && latchDelay == 2'h0 && !zeroFill)
      |=> readValid && readData == $past(memData);
  endproperty
  a_lat0: assert property (p_lat0)
    else $error("read data not latched at strobe release");

  property p_lat2;
    @(posedge core_clk) disable iff (!rst_b)
    (casRelease && latchDelay == 2'h2) |=> ##2 readValid;
  endproperty
  a_lat2: assert property (p_lat2)
    else $error("read latch delay of two clocks missed");
endmodule : drc_read_latch

// ### hw/drc_dram_ctrl.sv
`include "drc_defines.svh"
module drc_dram_ctrl
  import drc_pkg::*;
#(
  parameter int DataW = 32,
  parameter int Banks = 4,
  parameter int RowW = 12,
  parameter int WaveWords = 3
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [`DRC_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [1:0] reqBank,
  input wire logic [RowW-1:0] reqRow,
  input wire logic [3:0] reqWords,
  output logic reqDone,
  output logic [DataW-1:0] readData,
  output logic readValid,
  input wire logic staticActive,
  input wire logic staticWide16,
  input wire logic staticCycleDone,
  output logic staticSuspend,
  input wire logic [DataW-1:0] memData,
  output logic [RowW-1:0] rowAddr,
  output logic [Banks-1:0] rowStrobeN,
  output logic columnStrobeN
);
  localparam int WaveBits = WaveWords * 32;

  // ----------------------------------------
  // Registers and fields
  // ----------------------------------------
  logic [31:0] config_q; // dram_config
  logic [31:0] wave_q [WaveWords]; // cas_waveform_word
  logic [WaveBits-1:0] waveAll; // Words end to end
  logic [Banks-1:0] bankEnable;
  logic [1:0] rowBitsSel;
  logic halfRate;
  logic [3:0] precharge;
  logic [3:0] cbrWidth;
  logic [1:0] latchDelay;
  logic [14:0] interval;
  logic [31:0] regRdData_q;

  assign bankEnable = config_q[`DRC_F_BANK_EN];
  assign rowBitsSel = config_q[`DRC_F_ROW_BITS];
  assign halfRate = config_q[`DRC_F_HALF_RATE];
  assign precharge = config_q[`DRC_F_PRECHARGE];
  assign cbrWidth = config_q[`DRC_F_CBR_WIDTH];
  assign latchDelay = config_q[`DRC_F_LATCH_DLY];
  assign interval = config_q[`DRC_F_INTERVAL];

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  drc_state_type state_q; // Current state
  logic memPhase_q; // Memory clock phase
  logic [6:0] shiftIdx_q; // Next waveform bit
  logic [3:0] pulseCnt_q; // Released strobe pulses
  logic [3:0] words_q; // Pulses in burst
  logic lastStep_q; // Final pulse released
  logic isRead_q; // Burst is a read
  logic dummy_q; // Access hit a disabled bank
  logic [4:0] waitCnt_q; // Memory clocks left in wait
  logic [Banks-1:0] rowStrobeN_q;
  logic columnStrobeN_q;
  logic [RowW-1:0] rowAddr_q;
  logic reqDone_q;
  logic staticSuspend_q; // Static access paused
  logic staticPair_q; // First half of 16-bit pair seen

  // ----------------------------------------
  // Combinational helpers
  // ----------------------------------------
  logic memTick; // Last CPU clock of a memory clock
  logic shiftTick; // Waveform advances
  logic waveBit; // Bit due out next
  logic casRelease; // Column strobe rises at this edge
  logic waitDone; // Wait ends at this edge
  logic [4:0] preLoad; // Precharge memory clocks
  logic [RowW-1:0] rowMask; // Valid row bits
  logic refPend; // Refresh owed
  logic refStart; // Begin refresh now
  logic accept; // Request taken
  logic staticBreak; // Static access at a legal pause
  logic cbrEnd; // Refresh row strobe released

  assign memTick = memPhase_q;
  assign shiftTick = halfRate ? memTick : 1'b1;
  assign waveBit = (shiftIdx_q < 7'(WaveBits)) ?
    waveAll[shiftIdx_q] : 1'b1;
  assign casRelease = (state_q == ST_ACCESS) && shiftTick &&
    !lastStep_q && !columnStrobeN_q && waveBit;
  assign waitDone = memTick && (waitCnt_q == `DRC_WAIT_LAST);
  assign cbrEnd = (state_q == ST_CBR_RAS) && waitDone;

  // Precharge is the field plus one memory clocks, never under two
  always_comb begin
    preLoad = {1'b0, precharge} + 5'h01;
    if (preLoad < `DRC_MIN_PRECHARGE) begin
      preLoad = `DRC_MIN_PRECHARGE;
    end
  end

  // Row width 9 to 12 bits; upper bits forced low
  assign rowMask = `DRC_ROW_MASK_FULL >> (`DRC_ROW_SEL_MAX - rowBitsSel);

  // Refresh waits for idle and for any static access to pause;
  // PC-card cycles are not watched, they run on through it
  assign refStart = (state_q == ST_IDLE) && refPend &&
    (!staticActive || staticSuspend_q);
  assign reqReady = (state_q == ST_IDLE) && !refPend && !staticActive;
  assign accept = reqValid && reqReady;

  assign regRdData = regRdData_q;
  assign rowStrobeN = rowStrobeN_q;
  assign columnStrobeN = columnStrobeN_q;
  assign rowAddr = rowAddr_q;
  assign reqDone = reqDone_q;
  assign staticSuspend = staticSuspend_q;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      config_q <= `DRC_CONFIG_RESET;
    end else if (regWr && regAddr == `DRC_OFF_CONFIG) begin
      config_q <= regWrData;
    end
  end

  // One waveform word per entry
  for (genvar w = 0; w < WaveWords; w++) begin : g_wave
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        wave_q[w] <= `DRC_WAVE_RESET;
      end else if (regWr && regAddr == `DRC_ADDR_W'(
          `DRC_OFF_WAVE0 + w * `DRC_WORD_BYTES)) begin
        wave_q[w] <= regWrData;
      end
    end
    assign waveAll[w*32 +: 32] = wave_q[w];
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData_q <= 32'h0;
    end else if (!regRd) begin
      regRdData_q <= 32'h0;
    end else if (regAddr == `DRC_OFF_CONFIG) begin
      regRdData_q <= config_q;
    end else if (regAddr == `DRC_OFF_STATUS) begin
      regRdData_q <= 32'h0;
      regRdData_q[`DRC_F_ST_STATE] <= state_q;
      regRdData_q[`DRC_F_ST_SUSPEND] <= staticSuspend_q;
      regRdData_q[`DRC_F_ST_PENDING] <= refPend;
    end else begin
      regRdData_q <= 32'h0;
      for (int i = 0; i < WaveWords; i++) begin
        if (regAddr == `DRC_ADDR_W'(
            `DRC_OFF_WAVE0 + i * `DRC_WORD_BYTES)) begin
          regRdData_q <= wave_q[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Memory clock at half the CPU rate
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      memPhase_q <= 1'b0;
    end else begin
      memPhase_q <= !memPhase_q;
    end
  end

  // ----------------------------------------
  // Main sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      shiftIdx_q <= 7'h0;
      pulseCnt_q <= 4'h0;
      words_q <= 4'h0;
      lastStep_q <= 1'b0;
      isRead_q <= 1'b0;
      dummy_q <= 1'b0;
      waitCnt_q <= 5'h0;
      rowStrobeN_q <= '1;
      columnStrobeN_q <= 1'b1;
      rowAddr_q <= '0;
      reqDone_q <= 1'b0;
    end else begin
      reqDone_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (refStart || (accept && !bankEnable[reqBank])) begin
            // Column strobe leads for a CAS-before-RAS cycle
            dummy_q <= !refStart;
            columnStrobeN_q <= 1'b0;
            waitCnt_q <= `DRC_CBR_CAS_LEAD;
            state_q <= ST_CBR_CAS;
          end else if (accept) begin
            // Bit 0 goes out with the row strobe
            rowStrobeN_q <= ~(Banks'(1) << reqBank);
            rowAddr_q <= reqRow & rowMask;
            columnStrobeN_q <= waveAll[0];
            shiftIdx_q <= 7'h1;
            pulseCnt_q <= 4'h0;
            words_q <= reqWords;
            lastStep_q <= 1'b0;
            isRead_q <= !reqWrite;
            state_q <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          if (lastStep_q) begin
            // Row strobe rises the cycle after the last pulse
            rowStrobeN_q <= '1;
            columnStrobeN_q <= 1'b1;
            waitCnt_q <= preLoad;
            reqDone_q <= 1'b1;
            state_q <= ST_PRECHARGE;
          end else if (shiftTick) begin
            columnStrobeN_q <= waveBit;
            shiftIdx_q <= shiftIdx_q + 7'h1;
            if (casRelease) begin
              pulseCnt_q <= pulseCnt_q + 4'h1;
              // The burst stays whole until its last pulse
              lastStep_q <= (pulseCnt_q + 4'h1 == words_q);
            end
          end
        end
        ST_PRECHARGE: begin
          // Both strobes stay high the whole wait
          columnStrobeN_q <= 1'b1;
          if (waitDone) begin
            state_q <= ST_IDLE;
          end else if (memTick) begin
            waitCnt_q <= waitCnt_q - 5'h1;
          end
        end
        ST_CBR_CAS: begin
          if (waitDone) begin
            rowStrobeN_q <= '0;
            waitCnt_q <= {1'b0, cbrWidth} + 5'h01;
            state_q <= ST_CBR_RAS;
          end else if (memTick) begin
            waitCnt_q <= waitCnt_q - 5'h1;
          end
        end
        ST_CBR_RAS: begin
          if (waitDone) begin
            rowStrobeN_q <= '1;
            columnStrobeN_q <= 1'b1;
            waitCnt_q <= preLoad;
            reqDone_q <= dummy_q;
            dummy_q <= 1'b0;
            state_q <= ST_PRECHARGE;
          end else if (memTick) begin
            waitCnt_q <= waitCnt_q - 5'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Static memory pause points
  // ----------------------------------------
  // 16-bit bus pauses after each pair of cycles, 32-bit after one
  assign staticBreak = staticCycleDone &&
    (!staticWide16 || staticPair_q);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      staticPair_q <= 1'b0;
    end else if (!staticActive || !staticWide16) begin
      staticPair_q <= 1'b0;
    end else if (staticCycleDone) begin
      staticPair_q <= !staticPair_q;
    end
  end

  // Suspend holds until the refresh row strobe releases
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      staticSuspend_q <= 1'b0;
    end else if (refPend && staticActive && staticBreak) begin
      staticSuspend_q <= 1'b1;
    end else if (cbrEnd) begin
      staticSuspend_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  drc_refresh_timer #(
    .IntervalW(15)
  ) u_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .memTick(memTick),
    .timerEnable(|bankEnable),
    .interval(interval),
    .refreshAck(refStart),
    .refreshPending(refPend)
  );

  drc_read_latch #(
    .DataW(DataW),
    .DelayMax(3)
  ) u_latch (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .casRelease(casRelease && isRead_q),
    .zeroFill(cbrEnd && dummy_q),
    .latchDelay(latchDelay),
    .memData(memData),
    .readData(readData),
    .readValid(readValid)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_rowWidth;
    @(posedge core_clk) disable iff (!rst_b)
    state_q == ST_ACCESS |-> (rowAddr_q & ~rowMask) == '0;
  endproperty
  a_rowWidth: assert property (p_rowWidth)
    else $error("row address wider than selected");

  property p_halfRate;
    @(posedge core_clk) disable iff (!rst_b)
    (state_q == ST_ACCESS && halfRate && !memTick) |=>
      $stable(shiftIdx_q);
  endproperty
  a_halfRate: assert property (p_halfRate)
    else $error("waveform advanced off the memory clock");

  property p_precharge;
    @(posedge core_clk) disable iff (!rst_b)
    (state_q == ST_PRECHARGE && !waitDone) |=>
      state_q == ST_PRECHARGE && rowStrobeN_q == '1 && columnStrobeN_q;
  endproperty
  a_precharge: assert property (p_precharge)
    else $error("precharge cut short");

  property p_cbrWidth;
    @(posedge core_clk) disable iff (!rst_b)
    (state_q == ST_CBR_RAS && !waitDone) |=> state_q == ST_CBR_RAS;
  endproperty
  a_cbrWidth: assert property (p_cbrWidth)
    else $error("refresh row strobe released early");

  property p_allBanks;
    @(posedge core_clk) disable iff (!rst_b)
    state_q == ST_CBR_RAS |-> rowStrobeN_q == '0 && !columnStrobeN_q;
  endproperty
  a_allBanks: assert property (p_allBanks)
    else $error("refresh missed a bank");

  property p_noSplit;
    @(posedge core_clk) disable iff (!rst_b)
    $rose(state_q == ST_CBR_CAS) |-> $past(state_q) == ST_IDLE;
  endproperty
  a_noSplit: assert property (p_noSplit)
    else $error("refresh entered inside a burst");

  property p_waveform;
    @(posedge core_clk) disable iff (!rst_b)
    (state_q == ST_ACCESS && shiftTick && !lastStep_q) |=>
      columnStrobeN_q == $past(waveBit);
  endproperty
  a_waveform: assert property (p_waveform)
    else $error("column strobe does not follow waveform");

  property p_pause;
    @(posedge core_clk) disable iff (!rst_b)
    $rose(staticSuspend_q) |-> $past(staticBreak);
  endproperty
  a_pause: assert property (p_pause)
    else $error("static access paused mid cycle");
endmodule : drc_dram_ctrl

// ### sim/drc_dram_model.sv
module drc_dram_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] rowStrobeN,
  input wire logic columnStrobeN,
  input wire logic [11:0] rowAddr,
  output logic [31:0] memData,
  output int refCount,
  output int refGap,
  output int rasLen,
  output int casLen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] rasPrev; // Row strobes seen at the last edge
  logic [11:0] rowLatch; // Row opened by the current access
  logic dataOn; // Cell data held until one cycle after the row closes
  int now, lastRef, rasCnt, casCnt;
  // A released bus shows the inverse pattern, never a stale match
  assign memData = dataOn ? {20'ha5a50, rowLatch} : ~{20'ha5a50, rowLatch};
  // Strobe observer and cell array stand-in
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {now, lastRef, rasCnt, casCnt, refCount, refGap, rasLen, casLen} <= '0;
      rasPrev <= 4'hf;
      rowLatch <= 12'h000;
      dataOn <= 1'h0;
    end else begin
      now <= now + 1;
      rasPrev <= rowStrobeN;
      // All banks fall together behind an early column strobe
      if (rasPrev == 4'hf && rowStrobeN == 4'h0 && !columnStrobeN) begin
        refCount <= refCount + 1;
        refGap <= now - lastRef;
        lastRef <= now;
        rasCnt <= 1;
      end else if (rowStrobeN == 4'h0) begin
        rasCnt <= rasCnt + 1;
      end else if (rasPrev == 4'h0) begin
        rasLen <= rasCnt;
      end
      if (rasPrev == 4'hf && rowStrobeN != 4'hf && rowStrobeN != 4'h0) begin
        rowLatch <= rowAddr;
      end
      // Column strobe low opens the data output; it turns off one cycle
      // after the row closes, like a real output turn-off time
      if (rowStrobeN == 4'hf && rasPrev == 4'hf) begin
        dataOn <= 1'h0;
      end else if (!columnStrobeN) begin
        dataOn <= 1'h1;
      end
      if (!columnStrobeN) begin
        casCnt <= casCnt + 1;
      end else if (casCnt != 0) begin
        casLen <= casCnt;
        casCnt <= 0;
      end
    end
  end
endmodule : drc_dram_model

// ### sim/dram_timing_refresh_config_test.sv
`include "drc_defines.svh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %h seen %h", nm, e, a); end end
module dram_timing_refresh_config_test
  import drc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst_b, regWr, regRd, reqValid, reqReady, reqWrite, reqDone;
  logic readValid, staticActive, staticWide16, staticCycleDone, staticSuspend;
  logic columnStrobeN;
  logic [4:0] regAddr;
  logic [31:0] regWrData, regRdData, readData, memData, rv;
  logic [1:0] reqBank;
  logic [11:0] reqRow, rowAddr;
  logic [3:0] reqWords, rowStrobeN;
  int miscompares, n_checks, refCount, refGap, rasLen, casLen, base;
  // ----------------------------------------
  // Clock, design and memory model
  // ----------------------------------------
  always #2.5 core_clk = ~core_clk;
  drc_dram_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .reqBank(reqBank), .reqRow(reqRow),
    .reqWords(reqWords), .reqDone(reqDone), .readData(readData),
    .readValid(readValid), .staticActive(staticActive),
    .staticWide16(staticWide16), .staticCycleDone(staticCycleDone),
    .staticSuspend(staticSuspend), .memData(memData), .rowAddr(rowAddr),
    .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN));
  drc_dram_model dram (.core_clk(core_clk), .rst_b(rst_b),
    .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN),
    .rowAddr(rowAddr), .memData(memData), .refCount(refCount),
    .refGap(refGap), .rasLen(rasLen), .casLen(casLen));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  task automatic hang_out;
    miscompares++;
    $display("unexpected wait limit reached");
    stop_test();
  endtask : hang_out
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge core_clk);
    regWr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge core_clk);
    regRd <= 1'h0;
    @(negedge core_clk);
    d = regRdData;
  endtask : rd
  // Packs the configuration word field by field
  function automatic logic [31:0] cfg(logic [3:0] en, logic [1:0] rb,
    logic hf, logic [1:0] dly, logic [14:0] ival);
    return {ival, dly, 4'h2, 4'h1, hf, rb, en};
  endfunction : cfg
  // One DRAM read; every latched word must match the expected word
  task automatic dram_read(input logic [1:0] b, input logic [11:0] r,
    input logic [3:0] n, input logic [31:0] exp);
    int k, got, tail;
    got = 0;
    tail = 0;
    @(posedge core_clk);
    reqBank <= b;
    reqRow <= r;
    reqWords <= n;
    reqValid <= 1'h1;
    // Ready is judged between edges, never in the edge's own time step
    for (k = 0; k < 200; k++) begin
      @(negedge core_clk);
      if (reqReady === 1'h1) break;
    end
    if (k == 200) hang_out();
    @(posedge core_clk);
    reqValid <= 1'h0;
    // Late latch delays land after the done pulse; watch a few more
    for (k = 0; k < 300 && tail < 4; k++) begin
      @(negedge core_clk);
      if (readValid === 1'h1) begin
        got++;
        `CHK("readData", exp, readData)
      end
      if (reqDone === 1'h1 || tail > 0) tail++;
    end
    if (tail < 4) hang_out();
    `CHK("words", 32'(n), got)
  endtask : dram_read
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reg_scenario;
    rd(`DRC_OFF_CONFIG, rv);
    `CHK("cfgReset", `DRC_CONFIG_RESET, rv)
    wr(`DRC_OFF_CONFIG, cfg(4'h5, 2'h2, 1'h1, 2'h3, 15'h1234));
    rd(`DRC_OFF_CONFIG, rv);
    `CHK("cfgBack", cfg(4'h5, 2'h2, 1'h1, 2'h3, 15'h1234), rv)
    rd(5'h14, rv);
    `CHK("unmapped", 32'h0000_0000, rv)
    // Twenty-three column pulses over the three waveform words
    wr(`DRC_OFF_WAVE0, 32'hcccc_cccf);
    wr(5'h08, 32'hcccc_cccc);
    wr(5'h0c, 32'hcccc_cccc);
  endtask : reg_scenario
  task automatic read_scenario;
    for (int i = 0; i < 4; i++) begin
      wr(`DRC_OFF_CONFIG, cfg(4'hf, 2'(i), 1'(i), 2'(i), 15'h7fff));
      dram_read(2'(i), 12'hfff, 4'h2, {20'ha5a50, 12'hfff >> (3 - i)});
      `CHK("casLow", 2 << i[0], casLen)
    end
  endtask : read_scenario
  task automatic disabled_scenario;
    wr(`DRC_OFF_CONFIG, cfg(4'h1, 2'h3, 1'h0, 2'h0, 15'h7fff));
    base = refCount;
    dram_read(2'h2, 12'h000, 4'h1, 32'h0000_0000);
    `CHK("bankOffRefresh", base + 1, refCount)
  endtask : disabled_scenario
  task automatic refresh_scenario;
    int k;
    // Reset in mid-run so the timer starts from an empty count
    @(posedge core_clk);
    rst_b <= 1'h0;
    @(posedge core_clk);
    rst_b <= 1'h1;
    // Tiny interval so several refreshes fit in a short run
    wr(`DRC_OFF_CONFIG, cfg(4'hf, 2'h3, 1'h0, 2'h0, 15'h0003));
    base = refCount;
    for (k = 0; k < 400 && refCount < base + 3; k++) @(negedge core_clk);
    if (k == 400) hang_out();
    `CHK("gap", 1'h1, refGap >= 23 && refGap <= 25)
    `CHK("cbrRas", 1'h1, rasLen >= 5 && rasLen <= 6)
    // Freeze mid-interval: a running timer would refresh within 24
    wr(`DRC_OFF_CONFIG, cfg(4'h0, 2'h3, 1'h0, 2'h0, 15'h0003));
    base = refCount;
    repeat (100) @(posedge core_clk);
    `CHK("timerStopped", base, refCount)
    wr(`DRC_OFF_CONFIG, cfg(4'hf, 2'h3, 1'h0, 2'h0, 15'h0003));
  endtask : refresh_scenario
  task automatic static_scenario;
    int rises, dones;
    logic sPrev, dPrev;
    // 32-bit bus first, then the 16-bit bus that pauses after pairs
    for (int w = 0; w < 2; w++) begin
      {rises, dones, dPrev} = '0;
      sPrev = 1'h1;
      @(posedge core_clk);
      staticWide16 <= 1'(w);
      staticActive <= 1'h1;
      for (int k = 0; k < 120; k++) begin
        @(posedge core_clk);
        staticCycleDone <= (k % 4 == 0) && !sPrev;
        @(negedge core_clk);
        if (staticSuspend === 1'h1 && !sPrev) begin
          rises++;
          `CHK("suspendCause", 1'h1, dPrev)
          `CHK("pairDone", 0, w * (dones % 2))
        end
        sPrev = staticSuspend;
        dPrev = staticCycleDone;
        dones += 32'(staticCycleDone);
      end
      @(posedge core_clk);
      staticActive <= 1'h0;
      `CHK("suspended", 1'h1, rises > 0)
    end
  endtask : static_scenario
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {core_clk, rst_b, regWr, regRd, reqValid, reqWrite} = '0;
    {staticActive, staticWide16, staticCycleDone, regAddr} = '0;
    {regWrData, reqBank, reqRow, reqWords} = '0;
    {miscompares, n_checks} = '0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'h1;
    reg_scenario();
    read_scenario();
    disabled_scenario();
    refresh_scenario();
    static_scenario();
    stop_test();
  end
endmodule : dram_timing_refresh_config_test
